// >>> chan_cfg_pkg.sv
// Constants, field layouts and carrier types for the channel control register bank.
// Assumes a single 100 MHz clock domain and an AHB-Lite master on the same clock.
//
// Overview of operation
// - Bits 3:0 hold transmit channel.
// - Bits 7:4 hold receive channel.
// - Bits 16:8 are reserved, no function.
// - No vendor or custom bits: standard SFD.
// - Vendor bit: both directions use vendor SFD.
// - Vendor SFD at 110 kbps: 64 symbols.
// - Vendor SFD at 850 kbps: 8/16 from count; the code passes any programmed 8-bit count through.
// - 6.8 Mbps always uses 8-symbol SFD.
// - Vendor bit overrides both custom SFD bits.
// - Bits 19:18 pulse rate: 01=16, 10=64 MHz.
// - Transmit custom clear, vendor clear: standard SFD.
// - Bit 20 selects user SFD for transmit.
// - Bit 21 selects user SFD for receive.
// - Bits 26:22 hold transmit preamble code.
// - Bits 31:27 hold receive preamble code.

package chan_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  CHANNEL_CONFIG_IDX   = 8'h1f;
  localparam logic [7:0]  SFD_SYMBOL_COUNT_CFG_IDX   = 8'h21;
  localparam logic [7:0]  DATA_RATE_CFG_IDX    = 8'h22;
  localparam logic [7:0]  SFD_STATUS_IDX       = 8'h23;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions of channel_config.
  localparam int          TRANSMIT_CHANNEL_SEL_LSB          = 0;
  localparam int          RECEIVE_CHANNEL_SEL_LSB          = 4;
  localparam int          VENDOR_SFD_BIT       = 17;
  localparam int          RX_PRF_LSB           = 18;
  localparam int          TX_CUSTOM_SFD_BIT    = 20;
  localparam int          RX_CUSTOM_SFD_BIT    = 21;
  localparam int          TX_PREAMBLE_CODE_LSB         = 22;
  localparam int          RX_PREAMBLE_CODE_LSB         = 27;

  // Writable bits of channel_config; bits 16:8 are reserved.
  localparam logic [31:0] CHANNEL_CONFIG_MASK  = 32'hfffe_00ff;
  localparam logic [31:0] CHANNEL_CONFIG_RESET = 32'h0000_0055;

  localparam logic [7:0]  SFD_SYMBOL_COUNT_RESET     = 8'h08;
  localparam logic [7:0]  SFD_LEN_64           = 8'h40;
  localparam logic [7:0]  SFD_LEN_8            = 8'h08;

  ////////////////////////////////////////////////////////////////////////////////
  // Data rate, pulse rate and SFD source encodings.
  typedef enum logic [1:0] {
    RATE_110K = 2'b00,
    RATE_850K = 2'b01,
    RATE_6M8  = 2'b10
  } data_rate_t;

  localparam data_rate_t  DATA_RATE_RESET      = RATE_850K;

  localparam logic [1:0]  PRF_16MHZ            = 2'b01;
  localparam logic [1:0]  PRF_64MHZ            = 2'b10;

  typedef enum logic [1:0] {
    SFD_STANDARD = 2'b00,
    SFD_VENDOR   = 2'b01,
    SFD_USER     = 2'b10
  } sfd_mode_t;

  // Resolved configuration handed to the modem datapath.
  typedef struct packed {
    logic [3:0] tx_channel;
    logic [3:0] rx_channel;
    logic [1:0] rx_prf;
    logic [4:0] tx_preamble_code;
    logic [4:0] rx_preamble_code;
    sfd_mode_t  tx_sfd_mode;
    sfd_mode_t  rx_sfd_mode;
    logic [7:0] sfd_symbol_count;
  } chan_out_t;

endpackage

// >>> sfd_source_sel.sv
// SFD source selection for one direction (transmit or receive).
// Assumes the vendor and custom enables come straight from the control register.
`timescale 1ns/100ps

module sfd_source_sel (
  input  wire logic                   vendor_en_i,
  input  wire logic                   custom_en_i,
  output chan_cfg_pkg::sfd_mode_t     mode_o
);

  always_comb begin
    if (vendor_en_i) begin
      mode_o = chan_cfg_pkg::SFD_VENDOR;
    end else if (custom_en_i) begin
      mode_o = chan_cfg_pkg::SFD_USER;
    end else begin
      mode_o = chan_cfg_pkg::SFD_STANDARD;
    end
  end

endmodule // sfd_source_sel

// >>> uwb_channel_sfd_control.sv
// Channel control register bank with SFD source and length resolution.
// Assumes an AHB-Lite master on mclk_i; the slave never inserts wait states.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/100ps

module uwb_channel_sfd_control (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  // AHB-Lite slave port.
  input  wire logic                   hsel_i,
  input  wire logic [31:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic                   hready_i,
  input  wire logic [31:0]            hwdata_i,
  output logic      [31:0]            hrdata_o,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  // Resolved configuration.
  output chan_cfg_pkg::chan_out_t     cfg_o,
  output logic                        channel_mismatch_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address phase capture.

  logic                               wr_pend_reg;
  logic [7:0]                         wr_idx_reg;
  logic                               addr_ok;
  logic                               access;
  logic [7:0]                         acc_idx;

  // Only word-aligned accesses inside the first 1 KiB decode; writes must also be word sized.
  assign addr_ok = (haddr_i[31:10] == 22'h000000) && (haddr_i[1:0] == 2'b00);
  assign access  = hsel_i && hready_i && htrans_i[1];
  assign acc_idx = haddr_i[9:2];

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
    end else if (hready_i) begin
      wr_pend_reg <= access && hwrite_i && addr_ok && (hsize_i == 3'b010);
      wr_idx_reg  <= acc_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [31:0]                        channel_config_reg;
  logic [31:0]                        channel_config_next;
  logic [7:0]                         sfd_symbol_count_reg;
  logic [7:0]                         sfd_symbol_count_next;
  chan_cfg_pkg::data_rate_t           data_rate_reg;
  chan_cfg_pkg::data_rate_t           data_rate_next;
  logic                               wr_chan;
  logic                               wr_len;
  logic                               wr_rate;

  assign wr_chan = wr_pend_reg && (wr_idx_reg == chan_cfg_pkg::CHANNEL_CONFIG_IDX);
  assign wr_len  = wr_pend_reg && (wr_idx_reg == chan_cfg_pkg::SFD_SYMBOL_COUNT_CFG_IDX);
  assign wr_rate = wr_pend_reg && (wr_idx_reg == chan_cfg_pkg::DATA_RATE_CFG_IDX);

  always_comb begin
    channel_config_next = channel_config_reg;
    if (wr_chan) begin
      // Reserved bits stay zero whatever is written.
      channel_config_next = hwdata_i & chan_cfg_pkg::CHANNEL_CONFIG_MASK;
    end
  end

  always_comb begin
    sfd_symbol_count_next = sfd_symbol_count_reg;
    if (wr_len) begin
      sfd_symbol_count_next = hwdata_i[7:0];
    end
  end

  always_comb begin
    data_rate_next = data_rate_reg;
    if (wr_rate) begin
      data_rate_next = chan_cfg_pkg::data_rate_t'(hwdata_i[1:0]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      channel_config_reg <= chan_cfg_pkg::CHANNEL_CONFIG_RESET;
    end else begin
      channel_config_reg <= channel_config_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sfd_symbol_count_reg <= chan_cfg_pkg::SFD_SYMBOL_COUNT_RESET;
    end else begin
      sfd_symbol_count_reg <= sfd_symbol_count_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      data_rate_reg <= chan_cfg_pkg::DATA_RATE_RESET;
    end else begin
      data_rate_reg <= data_rate_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field extraction and SFD resolution.

  logic [3:0]                         transmit_channel_sel;
  logic [3:0]                         receive_channel_sel;
  logic [1:0]                         rx_prf;
  logic                               vendor_sfd;
  logic                               tx_custom;
  logic                               rx_custom;
  logic [4:0]                         tx_preamble_code;
  logic [4:0]                         rx_preamble_code;
  chan_cfg_pkg::sfd_mode_t            tx_mode;
  chan_cfg_pkg::sfd_mode_t            rx_mode;
  logic [7:0]                         sfd_len;

  assign transmit_channel_sel    = channel_config_reg[chan_cfg_pkg::TRANSMIT_CHANNEL_SEL_LSB +: 4];
  assign receive_channel_sel    = channel_config_reg[chan_cfg_pkg::RECEIVE_CHANNEL_SEL_LSB +: 4];
  assign vendor_sfd = channel_config_reg[chan_cfg_pkg::VENDOR_SFD_BIT];
  assign rx_prf     = channel_config_reg[chan_cfg_pkg::RX_PRF_LSB +: 2];
  assign tx_custom  = channel_config_reg[chan_cfg_pkg::TX_CUSTOM_SFD_BIT];
  assign rx_custom  = channel_config_reg[chan_cfg_pkg::RX_CUSTOM_SFD_BIT];
  assign tx_preamble_code   = channel_config_reg[chan_cfg_pkg::TX_PREAMBLE_CODE_LSB +: 5];
  assign rx_preamble_code   = channel_config_reg[chan_cfg_pkg::RX_PREAMBLE_CODE_LSB +: 5];

  sfd_source_sel u_tx_sfd (
    .vendor_en_i (vendor_sfd),
    .custom_en_i (tx_custom),
    .mode_o      (tx_mode)
  );

  sfd_source_sel u_rx_sfd (
    .vendor_en_i (vendor_sfd),
    .custom_en_i (rx_custom),
    .mode_o      (rx_mode)
  );

  // Length follows the data rate; 110 kbps is always 64 symbols and 6.8 Mbps
  // always 8. At 850 kbps a non-standard transmit SFD takes the programmed count.
  always_comb begin
    sfd_len = chan_cfg_pkg::SFD_LEN_8;
    unique case (data_rate_reg)
      chan_cfg_pkg::RATE_110K: begin
        sfd_len = chan_cfg_pkg::SFD_LEN_64;
      end
      chan_cfg_pkg::RATE_850K: begin
        if (tx_mode != chan_cfg_pkg::SFD_STANDARD) begin
          sfd_len = sfd_symbol_count_reg;
        end else begin
          sfd_len = chan_cfg_pkg::SFD_LEN_8;
        end
      end
      chan_cfg_pkg::RATE_6M8: begin
        sfd_len = chan_cfg_pkg::SFD_LEN_8;
      end
      default: begin
        sfd_len = chan_cfg_pkg::SFD_LEN_8;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs toward the modem.

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.tx_channel  <= transmit_channel_sel;
      cfg_o.rx_channel  <= receive_channel_sel;
      cfg_o.rx_prf      <= rx_prf;
      cfg_o.tx_preamble_code    <= tx_preamble_code;
      cfg_o.rx_preamble_code    <= rx_preamble_code;
      cfg_o.tx_sfd_mode <= tx_mode;
      cfg_o.rx_sfd_mode <= rx_mode;
      cfg_o.sfd_symbol_count  <= sfd_len;
    end
  end

  // Flags a software slip: channels differ or a value outside 1-5, 7.
  logic                               chan_bad;

  always_comb begin
    chan_bad = (transmit_channel_sel != receive_channel_sel);
    unique case (transmit_channel_sel)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7: begin
      end
      default: begin
        chan_bad = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      channel_mismatch_o <= 1'b0;
    end else begin
      channel_mismatch_o <= chan_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path. Register reads use the next values so a read right after a write sees it; status uses cfg_o.

  logic [31:0]                        rd_data;
  logic [31:0]                        status_word;

  assign status_word = {16'h0000, cfg_o.sfd_symbol_count, 3'b000, channel_mismatch_o,
                        cfg_o.rx_sfd_mode, cfg_o.tx_sfd_mode};

  always_comb begin
    rd_data = 32'h0000_0000;
    if (access && !hwrite_i && addr_ok) begin
      unique case (acc_idx)
        chan_cfg_pkg::CHANNEL_CONFIG_IDX: begin
          rd_data = channel_config_next;
        end
        chan_cfg_pkg::SFD_SYMBOL_COUNT_CFG_IDX: begin
          rd_data = {24'h000000, sfd_symbol_count_next};
        end
        chan_cfg_pkg::DATA_RATE_CFG_IDX: begin
          rd_data = {30'h00000000, data_rate_next};
        end
        chan_cfg_pkg::SFD_STATUS_IDX: begin
          rd_data = status_word;
        end
        default: begin
          rd_data = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hready_i) begin
      hrdata_o <= rd_data;
    end
  end

  // Zero wait states and OKAY for every transfer.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

endmodule // uwb_channel_sfd_control

// >>> uwb_channel_sfd_control_checker.sv
// Concurrent checks on the ports of the channel control register bank.
// Assumes the bus hready is the slave's own hreadyout and one clock domain.
`timescale 1ns/100ps

module uwb_channel_sfd_control_checker (
  input wire logic                    mclk_i,
  input wire logic                    rst_n_i,
  input wire logic                    hsel_i,
  input wire logic [31:0]             haddr_i,
  input wire logic [1:0]              htrans_i,
  input wire logic                    hwrite_i,
  input wire logic [2:0]              hsize_i,
  input wire logic                    hready_i,
  input wire logic [31:0]             hwdata_i,
  input wire logic [31:0]             hrdata_o,
  input wire chan_cfg_pkg::chan_out_t cfg_o,
  input wire logic                    channel_mismatch_o
);
  logic take;
  logic live_reg;
  logic wr_reg;
  logic rd_reg;

  // Address phase aimed at the channel word.
  assign take = hsel_i && hready_i && htrans_i[1] && (haddr_i == 32'h0000_007c);

  always_ff @(posedge mclk_i) begin
    live_reg <= rst_n_i;
  end

  // High during the data phase of a word write or a read of the channel word.
  always_ff @(posedge mclk_i) begin
    wr_reg <= rst_n_i && take && hwrite_i && (hsize_i == 3'h2);
    rd_reg <= rst_n_i && take && !hwrite_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_resv_read_zero: assert property (
    rd_reg |-> hrdata_o[16:8] == 9'h000) else $error("reserved bits read nonzero");
  a_transmit_channel_sel_field: assert property (
    wr_reg |-> ##2 cfg_o.tx_channel == $past(hwdata_i[3:0], 2)) else $error("tx channel wrong");
  a_receive_channel_sel_field: assert property (
    wr_reg |-> ##2 cfg_o.rx_channel == $past(hwdata_i[7:4], 2)) else $error("rx channel wrong");
  a_prf_field: assert property (
    wr_reg |-> ##2 cfg_o.rx_prf == $past(hwdata_i[19:18], 2)) else $error("pulse rate wrong");
  a_pcode_fields: assert property (
    wr_reg |-> ##2 {cfg_o.rx_preamble_code, cfg_o.tx_preamble_code} == $past(hwdata_i[31:22], 2))
    else $error("preamble codes wrong");
  a_tx_mode_sel: assert property (
    wr_reg |-> ##2 cfg_o.tx_sfd_mode == ($past(hwdata_i[17], 2) ? chan_cfg_pkg::SFD_VENDOR :
      $past(hwdata_i[20], 2) ? chan_cfg_pkg::SFD_USER : chan_cfg_pkg::SFD_STANDARD))
    else $error("tx sfd mode wrong");
  a_rx_mode_sel: assert property (
    wr_reg |-> ##2 cfg_o.rx_sfd_mode == ($past(hwdata_i[17], 2) ? chan_cfg_pkg::SFD_VENDOR :
      $past(hwdata_i[21], 2) ? chan_cfg_pkg::SFD_USER : chan_cfg_pkg::SFD_STANDARD))
    else $error("rx sfd mode wrong");
  a_vendor_pair: assert property (
    live_reg |-> (cfg_o.tx_sfd_mode == chan_cfg_pkg::SFD_VENDOR) ==
      (cfg_o.rx_sfd_mode == chan_cfg_pkg::SFD_VENDOR)) else $error("vendor mode one-sided");
  a_std_length: assert property (
    live_reg && cfg_o.tx_sfd_mode == chan_cfg_pkg::SFD_STANDARD |->
      cfg_o.sfd_symbol_count inside {8'h08, 8'h40}) else $error("standard sfd_symbol_count wrong");
  a_mismatch_flag: assert property (
    live_reg |-> channel_mismatch_o == ((cfg_o.tx_channel != cfg_o.rx_channel) ||
      !(cfg_o.tx_channel inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7})))
    else $error("channel mismatch flag wrong");
endmodule // uwb_channel_sfd_control_checker

bind uwb_channel_sfd_control uwb_channel_sfd_control_checker uwb_channel_sfd_control_checker_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i),
  .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .cfg_o(cfg_o),
  .channel_mismatch_o(channel_mismatch_o));

// >>> uwb_channel_sfd_control_tb.sv
// Self-checking bench for the channel control register bank.
// Assumes a lone AHB-Lite slave whose hreadyout is fed back as hready.
`timescale 1ns/100ps

module uwb_channel_sfd_control_tb;
  typedef struct {
    logic [31:0] chan;
    logic [7:0]  cnt;
    logic [1:0]  rate;
    logic [1:0]  tm;
    logic [1:0]  rm;
    logic [7:0]  len;
  } row_t;

  logic                    mclk_i;
  logic                    rst_n_i;
  logic                    hsel_i;
  logic [31:0]             haddr_i;
  logic [1:0]              htrans_i;
  logic                    hwrite_i;
  logic [2:0]              hsize_i;
  logic [31:0]             hwdata_i;
  logic [31:0]             hrdata_o;
  logic                    hreadyout_o;
  logic                    hresp_o;
  logic                    channel_mismatch_o;
  chan_cfg_pkg::chan_out_t cfg_o;
  chan_cfg_pkg::chan_out_t e;
  logic [31:0]             rd;
  logic                    mm;
  int                      bad_count;
  int                      tests_run;
  int                      cycles;

  // Channel word, symbol count, data rate; then tx mode, rx mode and length expected.
  row_t rows [10] = '{
    '{32'h0004_0055, 8'h08, 2'h0, 2'h0, 2'h0, 8'h40},
    '{32'h0004_0055, 8'h10, 2'h1, 2'h0, 2'h0, 8'h08},
    '{32'hf836_0077, 8'h10, 2'h0, 2'h1, 2'h1, 8'h40},
    '{32'h0846_0011, 8'h10, 2'h1, 2'h1, 2'h1, 8'h10},
    '{32'h0006_0022, 8'h08, 2'h1, 2'h1, 2'h1, 8'h08},
    '{32'h0006_0077, 8'h10, 2'h2, 2'h1, 2'h1, 8'h08},
    '{32'h07d4_0033, 8'h10, 2'h1, 2'h2, 2'h0, 8'h10},
    '{32'h0024_0044, 8'h10, 2'h1, 2'h0, 2'h2, 8'h08},
    '{32'h0008_0011, 8'h08, 2'h2, 2'h0, 2'h0, 8'h08},
    '{32'h0005_ff12, 8'h08, 2'h0, 2'h0, 2'h0, 8'h40}
  };

  uwb_channel_sfd_control uwb_channel_sfd_control_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hreadyout_o),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .cfg_o(cfg_o), .channel_mismatch_o(channel_mismatch_o));

  //////////////////////////////////////////////////////////////////////////////
  always #5 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg(input chan_cfg_pkg::chan_out_t got, input chan_cfg_pkg::chan_out_t exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t cfg got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single transfer; read data lands in rd at the end of the data phase.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [2:0] sz);
    @(posedge mclk_i);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    hsize_i  <= sz;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    rst_n_i = 1'b0;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    do_reset();
    foreach (rows[i]) begin
      xfer(1'b1, 32'h84, {24'h0, rows[i].cnt}, 3'h2);
      xfer(1'b1, 32'h88, {30'h0, rows[i].rate}, 3'h2);
      xfer(1'b1, 32'h7c, rows[i].chan, 3'h2);
      xfer(1'b0, 32'h7c, 32'h0, 3'h2);
      chk(rd, rows[i].chan & chan_cfg_pkg::CHANNEL_CONFIG_MASK);
      repeat (2) @(posedge mclk_i);
      #1;
      e.tx_channel = rows[i].chan[3:0];
      e.rx_channel = rows[i].chan[7:4];
      e.rx_prf = rows[i].chan[19:18];
      e.tx_preamble_code = rows[i].chan[26:22];
      e.rx_preamble_code = rows[i].chan[31:27];
      e.tx_sfd_mode = chan_cfg_pkg::sfd_mode_t'(rows[i].tm);
      e.rx_sfd_mode = chan_cfg_pkg::sfd_mode_t'(rows[i].rm);
      e.sfd_symbol_count = rows[i].len;
      mm = (e.tx_channel != e.rx_channel) ||
           !(e.tx_channel inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7});
      chk_cfg(cfg_o, e);
      chk({31'h0, channel_mismatch_o}, {31'h0, mm});
    end
    // A second reset in mid-run must bring back the reset configuration.
    do_reset();
    chk_cfg(cfg_o, chan_cfg_pkg::chan_out_t'(32'h5500_0008));
    xfer(1'b0, 32'h7c, 32'h0, 3'h2);
    chk(rd, 32'h0000_0055);
    // Status word after reset: length 8, no mismatch, both directions standard.
    xfer(1'b0, 32'h8c, 32'h0, 3'h2);
    chk(rd, 32'h0000_0800);
    chk({30'h0, hresp_o, hreadyout_o}, 32'h0000_0001);
    xfer(1'b1, 32'h7c, 32'h0004_0011, 3'h0);
    xfer(1'b0, 32'h7c, 32'h0, 3'h2);
    chk(rd, 32'h0000_0055);
    xfer(1'b1, 32'h40, 32'hffff_ffff, 3'h2);
    xfer(1'b0, 32'h40, 32'h0, 3'h2);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule // uwb_channel_sfd_control_tb
